// ### hdl/sbs_regs.vh
// Register offsets, field positions, operation codes, reset values and bus responses of the subtract and bit skip unit.
// Assumes inclusion by bare name from the unit's design files.
`ifndef SBS_REGS_VH
`define SBS_REGS_VH

// Byte addresses on the AXI4-Lite bus, one aligned word per register.
`define SBS_ACCUM_OFS 8'h00
`define SBS_FLAGS_OFS 8'h04
`define SBS_CMD_OFS 8'h08
`define SBS_STATUS_OFS 8'h0C
`define SBS_MEM_BASE 8'h40
`define SBS_MEM_DEPTH 16

// Flag register bits.
`define SBS_FLAG_C 0
`define SBS_FLAG_AUX 1
`define SBS_FLAG_Z 2
`define SBS_FLAG_OVF 3

// Command register fields.
`define SBS_CMD_OP_LSB 0
`define SBS_CMD_BIT_LSB 4
`define SBS_CMD_IMM_LSB 8
`define SBS_CMD_ADDR_LSB 16

// Operation codes.
`define SBS_OP_SKIP 2'h0
`define SBS_OP_SUB 2'h1
`define SBS_OP_SUBMEM 2'h2
`define SBS_OP_SUBI 2'h3

// Reset values.
`define SBS_ACCUM_RST 8'h00
`define SBS_FLAGS_RST 4'h0

// Bus responses.
`define SBS_RESP_OKAY 2'h0
`define SBS_RESP_SLVERR 2'h2

`endif

// ### hdl/sbs_sub.v
// Eight-bit subtractor with the four arithmetic flags.
// Assumes purely combinational use inside the subtract and bit skip unit.
`timescale 1ns/100ps
module sbs_sub (
    input wire [7:0] minuend,
    input wire [7:0] subtrahend,
    output wire [7:0] diff,
    output wire carry,
    output wire aux_carry,
    output wire zero,
    output wire overflow
);
    wire [8:0] full_w;
    wire [4:0] low_w;

    assign full_w = {1'b0, minuend} - {1'b0, subtrahend};
    assign low_w = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    assign diff = full_w[7:0];
    // A borrow out of bit 7 means a negative result, so carry reads low then. see RULE7
    assign carry = ~full_w[8]; // see RULE7
    assign aux_carry = ~low_w[4]; // see RULE8
    assign zero = (full_w[7:0] == 8'h00); // see RULE8
    assign overflow = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_w[7]); // see RULE8
endmodule // sbs_sub

// ### hdl/sbs_core.v
// Subtract and bit skip unit of a small 8-bit core, reached over an AXI4-Lite slave port.
// Assumes one clock, a synchronous active-high reset and a bus master keeping AXI4-Lite rules.
//
// How it works
// RULE1 - Set tested bit discards the following instruction.
// RULE2 - Bit-test skip always lasts two cycles.
// RULE3 - Clear bit continues; skip never touches flags.
// RULE4 - Register subtract writes accumulator, memory kept.
// RULE5 - Memory-destination subtract writes difference to memory.
// RULE6 - Immediate subtract writes accumulator.
// RULE7 - Carry cleared on borrow, else set.
// RULE8 - Subtracts update overflow, zero, aux carry.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "sbs_regs.vh"
module sbs_core #(
    parameter MEM_DEPTH = `SBS_MEM_DEPTH
) (
    input wire REF_CLK,
    input wire SRST,
    input wire CE,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output reg BUSY,
    output reg SKIP_NEXT
);
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_DUMMY = 2'h2;

    reg [7:0] mem_r [0:MEM_DEPTH-1];
    reg [7:0] accumulator_r;
    reg carry_flag_r;
    reg aux_carry_flag_r;
    reg zero_flag_r;
    reg overflow_flag_r;
    reg [1:0] st_r;
    reg [1:0] op_r;
    reg [2:0] bit_r;
    reg [7:0] imm_r;
    reg [3:0] addr_r;
    reg skip_taken_r;
    reg [7:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_held_r;
    reg w_held_r;

    wire [7:0] mem_sel;
    wire [7:0] sub_rhs;
    wire [7:0] diff;
    wire c_new;
    wire aux_new;
    wire z_new;
    wire ovf_new;
    wire wr_go;
    wire wr_is_mem;
    wire wr_ok;
    wire [3:0] wr_idx;
    wire rd_is_mem;
    wire [3:0] rd_idx;
    reg [31:0] rd_word;
    reg rd_ok;

    assign mem_sel = mem_r[addr_r];
    assign sub_rhs = (op_r == `SBS_OP_SUBI) ? imm_r : mem_sel; // see RULE6

    sbs_sub u_sub (
        .minuend(accumulator_r),
        .subtrahend(sub_rhs),
        .diff(diff),
        .carry(c_new),
        .aux_carry(aux_new),
        .zero(z_new),
        .overflow(ovf_new)
    );

    // A write completes once both address and data have been captured.
    assign wr_go = aw_held_r && w_held_r && !S_AXI_BVALID;
    assign wr_is_mem = (awaddr_r[7:6] == 2'b01) && (awaddr_r[5:2] < MEM_DEPTH);
    assign wr_idx = awaddr_r[5:2];
    // Writes are refused while an operation runs, so bus and datapath never race for a register.
    assign wr_ok = (st_r == ST_IDLE) && !awaddr_r[1] && !awaddr_r[0] && (wr_is_mem ||
        awaddr_r == `SBS_ACCUM_OFS || awaddr_r == `SBS_FLAGS_OFS || awaddr_r == `SBS_CMD_OFS);
    assign rd_is_mem = (S_AXI_ARADDR[7:6] == 2'b01) && (S_AXI_ARADDR[5:2] < MEM_DEPTH);
    assign rd_idx = S_AXI_ARADDR[5:2];

    always @* begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (S_AXI_ARADDR[1:0] != 2'b00) begin
            rd_ok = 1'b0;
        end else if (rd_is_mem) begin
            rd_word = {24'h00_0000, mem_r[rd_idx]};
        end else begin
            case (S_AXI_ARADDR)
                `SBS_ACCUM_OFS: rd_word = {24'h00_0000, accumulator_r};
                `SBS_FLAGS_OFS: rd_word = {28'h000_0000, overflow_flag_r, zero_flag_r,
                    aux_carry_flag_r, carry_flag_r};
                `SBS_CMD_OFS: rd_word = {12'h000, addr_r, imm_r, 1'b0, bit_r, 2'b00, op_r};
                `SBS_STATUS_OFS: rd_word = {28'h000_0000, 1'b0, st_r == ST_DUMMY, skip_taken_r,
                    st_r != ST_IDLE};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // Bus write channel.
    always @(posedge REF_CLK) begin
        if (SRST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `SBS_RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (CE) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            if (S_AXI_AWVALID && !aw_held_r && !S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
                aw_held_r <= 1'b1;
            end
            if (S_AXI_WVALID && !w_held_r && !S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
                w_held_r <= 1'b1;
            end
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? `SBS_RESP_OKAY : `SBS_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // Bus read channel.
    always @(posedge REF_CLK) begin
        if (SRST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `SBS_RESP_OKAY;
        end else if (CE) begin
            S_AXI_ARREADY <= 1'b0;
            if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID) begin
                S_AXI_ARREADY <= 1'b1;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_ok ? rd_word : 32'h0000_0000;
                S_AXI_RRESP <= rd_ok ? `SBS_RESP_OKAY : `SBS_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Data memory, written by the bus or by the memory-destination subtract.
    genvar gi;
    generate
        for (gi = 0; gi < MEM_DEPTH; gi = gi + 1) begin : g_mem
            always @(posedge REF_CLK) begin
                if (SRST) begin
                    mem_r[gi] <= 8'h00;
                end else if (CE) begin
                    if (st_r == ST_EXEC && op_r == `SBS_OP_SUBMEM && addr_r == gi) begin
                        mem_r[gi] <= diff; // see RULE5
                    end else if (wr_go && wr_ok && wr_is_mem && wr_idx == gi && wstrb_r[0]) begin
                        mem_r[gi] <= wdata_r[7:0];
                    end
                end
            end
        end
    endgenerate

    // Operation sequencer and architectural state.
    always @(posedge REF_CLK) begin
        if (SRST) begin
            st_r <= ST_IDLE;
            op_r <= `SBS_OP_SKIP;
            bit_r <= 3'h0;
            imm_r <= 8'h00;
            addr_r <= 4'h0;
            skip_taken_r <= 1'b0;
            accumulator_r <= `SBS_ACCUM_RST;
            {overflow_flag_r, zero_flag_r, aux_carry_flag_r, carry_flag_r} <= `SBS_FLAGS_RST;
            BUSY <= 1'b0;
            SKIP_NEXT <= 1'b0;
        end else if (CE) begin
            SKIP_NEXT <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (wr_go && wr_ok) begin
                        if (awaddr_r == `SBS_ACCUM_OFS && wstrb_r[0]) begin
                            accumulator_r <= wdata_r[7:0];
                        end
                        if (awaddr_r == `SBS_FLAGS_OFS && wstrb_r[0]) begin
                            carry_flag_r <= wdata_r[`SBS_FLAG_C];
                            aux_carry_flag_r <= wdata_r[`SBS_FLAG_AUX];
                            zero_flag_r <= wdata_r[`SBS_FLAG_Z];
                            overflow_flag_r <= wdata_r[`SBS_FLAG_OVF];
                        end
                        if (awaddr_r == `SBS_CMD_OFS && wstrb_r == 4'hF) begin
                            op_r <= wdata_r[`SBS_CMD_OP_LSB +: 2];
                            bit_r <= wdata_r[`SBS_CMD_BIT_LSB +: 3];
                            imm_r <= wdata_r[`SBS_CMD_IMM_LSB +: 8];
                            addr_r <= wdata_r[`SBS_CMD_ADDR_LSB +: 4];
                            st_r <= ST_EXEC;
                            BUSY <= 1'b1;
                        end
                    end
                end
                ST_EXEC: begin
                    if (op_r == `SBS_OP_SKIP) begin
                        // Flags are left alone whatever the tested bit holds. see RULE3
                        skip_taken_r <= mem_sel[bit_r]; // see RULE1
                        st_r <= ST_DUMMY; // see RULE2
                    end else begin
                        if (op_r != `SBS_OP_SUBMEM) begin
                            accumulator_r <= diff; // see RULE4
                        end
                        carry_flag_r <= c_new; // see RULE7
                        aux_carry_flag_r <= aux_new; // see RULE8
                        zero_flag_r <= z_new; // see RULE8
                        overflow_flag_r <= ovf_new; // see RULE8
                        skip_taken_r <= 1'b0;
                        st_r <= ST_IDLE;
                        BUSY <= 1'b0;
                    end
                end
                ST_DUMMY: begin
                    // The dummy cycle stands in for the fetched successor, which a set bit discards.
                    SKIP_NEXT <= skip_taken_r; // see RULE1
                    st_r <= ST_IDLE; // see RULE2
                    BUSY <= 1'b0;
                end
                default: begin
                    st_r <= ST_IDLE;
                    BUSY <= 1'b0;
                end
            endcase
        end
    end
endmodule // sbs_core

// ### tb/sbs_core_properties.sv
// Port checker for the subtract and bit skip unit.
// Assumes CE held high; bound into sbs_core below.
`timescale 1ns/100ps
module sbs_core_properties (
    input wire REF_CLK,
    input wire SRST,
    input wire S_AXI_BVALID,
    input wire S_AXI_ARREADY,
    input wire S_AXI_RVALID,
    input wire [1:0] S_AXI_RRESP,
    input wire [31:0] S_AXI_RDATA,
    input wire BUSY,
    input wire SKIP_NEXT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence skip_run;
        $rose(BUSY) ##1 BUSY;
    endsequence
    chk_skip_pulse: assert property (SKIP_NEXT |=> !SKIP_NEXT)
        else $error("skip pulse longer than one cycle");
    chk_skip_end: assert property (SKIP_NEXT |-> $fell(BUSY))
        else $error("skip pulse away from end of operation");
    chk_skip_two: assert property (SKIP_NEXT |-> $past(BUSY, 2))
        else $error("skip pulse after a single busy cycle");
    chk_busy_run: assert property (skip_run |=> !BUSY)
        else $error("operation longer than two cycles");
    chk_busy_short: assert property ($rose(BUSY) |-> ##[1:2] !BUSY)
        else $error("busy stuck high");
    chk_busy_start: assert property ($rose(BUSY) |-> $rose(S_AXI_BVALID))
        else $error("busy rose without a write response");
    chk_read_answer: assert property ($rose(S_AXI_ARREADY) |-> S_AXI_RVALID)
        else $error("read accepted without data valid");
    chk_read_refused: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0000_0000)
        else $error("refused read returned data");
endmodule // sbs_core_properties
bind sbs_core sbs_core_properties chk_u (
    .REF_CLK(REF_CLK),
    .SRST(SRST),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RDATA(S_AXI_RDATA),
    .BUSY(BUSY),
    .SKIP_NEXT(SKIP_NEXT)
);

// ### tb/test_subtract_and_bit_skip_ops.sv
// Self-checking bench for the subtract and bit skip unit.
// Assumes the map of sbs_regs.vh; CE is held high throughout.
`timescale 1ns/100ps
`include "sbs_regs.vh"
module test_subtract_and_bit_skip_ops;
    logic REF_CLK = 1'b0, SRST = 1'b1, CE = 1'b1;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA, d;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
    logic S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic BUSY, SKIP_NEXT;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
    int error_cnt = 0, check_count = 0, bc = 0, sc = 0, b0, s0, i;
    sbs_core dut_u (
        .REF_CLK(REF_CLK),
        .SRST(SRST),
        .CE(CE),
        .S_AXI_AWADDR(S_AXI_AWADDR),
        .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB),
        .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY),
        .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_BVALID(S_AXI_BVALID),
        .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR),
        .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY),
        .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP),
        .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY),
        .BUSY(BUSY),
        .SKIP_NEXT(SKIP_NEXT)
    );
    always #5 REF_CLK = ~REF_CLK;
    // Counting on the clock keeps the one-cycle skip pulse from being missed between tasks.
    always @(posedge REF_CLK) begin
        bc <= bc + (BUSY === 1'b1);
        sc <= sc + (SKIP_NEXT === 1'b1);
    end
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic hang;
        error_cnt++;
        $display("FAIL handshake expected 1 seen 0");
        results;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge REF_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= v;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (i = 0; i < 40 && S_AXI_BVALID !== 1'b1; i++) begin
            @(posedge REF_CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end
        if (i == 40) hang;
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge REF_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (i = 0; i < 40 && S_AXI_RVALID !== 1'b1; i++) begin
            @(posedge REF_CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end
        if (i == 40) hang;
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask
    task automatic op(input logic [1:0] c, input logic [2:0] bn, input logic [7:0] im, input logic [3:0] ad,
        input int be, input int se);
        b0 = bc;
        s0 = sc;
        wr(`SBS_CMD_OFS, {12'h000, ad, im, 1'b0, bn, 2'b00, c});
        for (i = 0; i < 20 && BUSY !== 1'b0; i++) @(posedge REF_CLK);
        if (i == 20) hang;
        repeat (2) @(posedge REF_CLK);
        check("busy cycles", bc - b0, be);
        check("skip pulses", sc - s0, se);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        check(n, d, e);
    endtask
    initial begin
        repeat (6) @(posedge REF_CLK);
        SRST <= 1'b0;
        rc(`SBS_ACCUM_OFS, 32'h0000_0000, "accumulator reset");
        rc(`SBS_FLAGS_OFS, 32'h0000_0000, "flags reset");
        $display("test reset done");
        wr(8'h4C, 32'h0000_0005);
        check("mapped write resp", {30'h0, r}, {30'h0, `SBS_RESP_OKAY});
        wr(`SBS_ACCUM_OFS, 32'h0000_0003);
        wr(`SBS_FLAGS_OFS, 32'h0000_000F);
        op(`SBS_OP_SUB, 3'h0, 8'h00, 4'h3, 1, 0);
        rc(`SBS_ACCUM_OFS, 32'h0000_00FE, "sub accumulator");
        rc(8'h4C, 32'h0000_0005, "sub memory kept");
        rc(`SBS_FLAGS_OFS, 32'h0000_0000, "sub flags");
        $display("test register subtract done");
        wr(`SBS_ACCUM_OFS, 32'h0000_0080);
        op(`SBS_OP_SUBI, 3'h0, 8'h01, 4'h0, 1, 0);
        rc(`SBS_ACCUM_OFS, 32'h0000_007F, "immediate accumulator");
        rc(`SBS_FLAGS_OFS, 32'h0000_0009, "immediate flags");
        $display("test immediate subtract done");
        wr(`SBS_ACCUM_OFS, 32'h0000_0010);
        wr(8'h54, 32'h0000_0010);
        op(`SBS_OP_SUBMEM, 3'h0, 8'h00, 4'h5, 1, 0);
        rc(8'h54, 32'h0000_0000, "into memory result");
        rc(`SBS_ACCUM_OFS, 32'h0000_0010, "into memory accumulator kept");
        rc(`SBS_FLAGS_OFS, 32'h0000_0007, "into memory flags");
        $display("test memory subtract done");
        wr(8'h48, 32'h0000_0080);
        op(`SBS_OP_SKIP, 3'h7, 8'h00, 4'h2, 2, 1);
        rc(`SBS_FLAGS_OFS, 32'h0000_0007, "skip set flags");
        rc(`SBS_STATUS_OFS, 32'h0000_0002, "skip set status");
        op(`SBS_OP_SKIP, 3'h6, 8'h00, 4'h2, 2, 0);
        rc(`SBS_FLAGS_OFS, 32'h0000_0007, "skip clear flags");
        rc(`SBS_STATUS_OFS, 32'h0000_0000, "skip clear status");
        $display("test bit skip done");
        rd(8'h30);
        check("unmapped read resp", {30'h0, r}, {30'h0, `SBS_RESP_SLVERR});
        wr(8'h30, 32'h0000_0001);
        check("unmapped write resp", {30'h0, r}, {30'h0, `SBS_RESP_SLVERR});
        $display("test unmapped done");
        results;
    end
endmodule // test_subtract_and_bit_skip_ops
